// ---- rtl/hp_port_pkg.sv ----
// Constants and types shared by the hot-plug two-wire register port
// Summary of operation
// - Respond to 7-bit address: fixed upper six bits, low bit from select pin.
// - Start is data falling while clock is high; device detects it.
// - Bits move on rising clock edge; high data is one, low is zero.
// - Receiver of each byte pulls data low on ninth clock; more may follow.
// - First byte is address with direction low; accept only full match.
// - After match, second byte selects register, third byte is stored only if it selects the control write register.
// - After acknowledging read address, drive out selected register's eight bits.
// - Control bits 0 and 2 let slot interrupts reach the low interrupt pin.
// - Control bits 1 and 3 enable slot A and slot B main switches.
// - Control bit 4 set resets pending latch-switch edge interrupts; zero rearms.
// - Control bits 5 to 7 are spare storage, read back in place.
// - Status shows per slot power healthy, aux healthy, interrupt request.
// - Status bit 6 is live system power good level; bit 7 reads zero.
// - Control readback returns all control bits in their written positions.
// - Slot A status bits 0-4: enable, input UV, output UV, overload, thermal.
// - Slot A status bit 5 is latch switch: delayed rise, immediate fall.
// - Slot A status bit 6 is slot healthy, bit 7 slot main fault.
// - Allow bits gate only the pin; request status bits still set.
// - Select pin low gives address bit zero, else one; supply gives test mode.
// - Latched main faults clear when slot enable is cycled or power cycled.
`default_nettype none
package hp_port_pkg;
    localparam logic [5:0] TARGET_ADDR_HIGH = 6'h10;
    localparam logic [7:0] REG_SLOT_CONTROL_WRITE = 8'h00;
    localparam logic [7:0] REG_POWER_STATUS = 8'h10;
    localparam logic [7:0] REG_CONTROL_READBACK = 8'h11;
    localparam logic [7:0] REG_SLOT_A_FAULT_STATUS = 8'h12;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int CTRL_A_ALLOW = 0;
    localparam int CTRL_A_ENABLE = 1;
    localparam int CTRL_B_ALLOW = 2;
    localparam int CTRL_B_ENABLE = 3;
    localparam int CTRL_SW_RESET = 4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int SW_RISE_DELAY_US = 10;
    localparam int SW_RISE_DELAY_CYCLES =
        (SW_RISE_DELAY_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int DELAY_CNT_W = 16;
    typedef enum logic [3:0] {
        LS_IDLE,
        LS_ADDR,
        LS_ADDR_ACK,
        LS_INDEX,
        LS_INDEX_ACK,
        LS_DATA,
        LS_DATA_ACK,
        LS_READ_BITS,
        LS_READ_ACK,
        LS_IGNORE
    } link_state_type;
    localparam link_state_type LINK_STATE_RESET = LS_IDLE;
endpackage : hp_port_pkg
`default_nettype wire

// ---- rtl/bit_sync2.sv ----
// Two-flop level synchroniser for a vector of independent bits
`default_nettype none
module bit_sync2
    import hp_port_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_type;

    sync_state_type cur_r;
    sync_state_type cur_nxt;

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.meta = d;
        cur_nxt.stable = cur_r.meta;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cur_r <= '0;
        else
            cur_r <= cur_nxt;
    end

    assign q = cur_r.stable;
endmodule : bit_sync2
`default_nettype wire

// ---- rtl/scl_bit_capture.sv ----
// Link-clock side: samples the data line on each rising serial clock edge
`default_nettype none
module scl_bit_capture
    import hp_port_pkg::*;
(
    input wire logic scl_clk,
    input wire logic rst_b,
    input wire logic sda_in,
    output logic bit_value,
    output logic bit_toggle
);
    typedef struct packed {
        logic value;
        logic toggle;
    } capture_state_type;

    capture_state_type cur_r;
    capture_state_type cur_nxt;

    // Bit stays stable a full clock period, so the toggle qualifies it
    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.value = sda_in;
        cur_nxt.toggle = ~cur_r.toggle;
    end

    always_ff @(posedge scl_clk)
    begin
        if (!rst_b)
            cur_r <= '0;
        else
            cur_r <= cur_nxt;
    end

    assign bit_value = cur_r.value;
    assign bit_toggle = cur_r.toggle;
endmodule : scl_bit_capture
`default_nettype wire

// ---- rtl/hp_register_port.sv ----
// Two-wire target register port of the dual-slot hot-plug controller
`default_nettype none
module hp_register_port
    import hp_port_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic SCL_CLK,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic ADDRESS_SELECT_PIN_LOW,
    input wire logic ADDRESS_SELECT_PIN_SUPPLY,
    input wire logic SYSTEM_POWER_GOOD,
    input wire logic SLOT_A_POWER_HEALTHY,
    input wire logic SLOT_A_AUX_HEALTHY,
    input wire logic SLOT_A_FAULT_IRQ,
    input wire logic SLOT_B_POWER_HEALTHY,
    input wire logic SLOT_B_AUX_HEALTHY,
    input wire logic SLOT_B_FAULT_IRQ,
    input wire logic SLOT_A_IN_UV_FAULT,
    input wire logic SLOT_A_OUT_UV_FAULT,
    input wire logic SLOT_A_OVERLOAD,
    input wire logic THERMAL_FAULT,
    input wire logic SLOT_A_MAIN_FAULT,
    input wire logic SLOT_A_LATCH_SWITCH,
    input wire logic SLOT_B_LATCH_SWITCH,
    output logic SLOT_A_ENABLE,
    output logic SLOT_B_ENABLE,
    output logic IRQ_N,
    output logic TEST_MODE_MASK
);
    localparam int SYNC_W = 19;

    typedef struct packed {
        link_state_type state;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic [7:0] index;
        logic [7:0] ctrl;
        logic [7:0] tx;
        logic sda_oe;
        logic sda_out;
        logic tog_prev;
        logic scl_prev;
        logic sda_prev;
        logic sw_a_prev;
        logic sw_b_prev;
        logic sw_pend_a;
        logic sw_pend_b;
        logic sw_a_filt;
        logic [DELAY_CNT_W-1:0] dly_cnt;
        logic irq_n;
        logic en_a;
        logic en_b;
        logic test_mode;
    } port_state_type;

    port_state_type cur_r;
    port_state_type cur_nxt;

    logic [SYNC_W-1:0] sync_q;
    logic cap_bit;
    logic cap_tog;
    logic scl_s, sda_s, tog_s, addr_low_s, addr_sup_s, sys_pg_s;
    logic a_ok_s, a_aux_s, a_firq_s, b_ok_s, b_aux_s, b_firq_s;
    logic a_inuv_s, a_outuv_s, a_ovl_s, therm_s, a_mf_s, sw_a_s, sw_b_s;
    logic start_det, stop_det, bit_evt, scl_fall, addr_bit;
    logic irq_a, irq_b;
    logic [7:0] word;

    scl_bit_capture u_capture (
        .scl_clk(SCL_CLK),
        .rst_b(RST_B),
        .sda_in(SDA_IN),
        .bit_value(cap_bit),
        .bit_toggle(cap_tog)
    );

    bit_sync2 #(.WIDTH(SYNC_W)) u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d({SCL_CLK, SDA_IN, cap_tog, ADDRESS_SELECT_PIN_LOW,
            ADDRESS_SELECT_PIN_SUPPLY, SYSTEM_POWER_GOOD,
            SLOT_A_POWER_HEALTHY, SLOT_A_AUX_HEALTHY, SLOT_A_FAULT_IRQ,
            SLOT_B_POWER_HEALTHY, SLOT_B_AUX_HEALTHY, SLOT_B_FAULT_IRQ,
            SLOT_A_IN_UV_FAULT, SLOT_A_OUT_UV_FAULT, SLOT_A_OVERLOAD,
            THERMAL_FAULT, SLOT_A_MAIN_FAULT, SLOT_A_LATCH_SWITCH,
            SLOT_B_LATCH_SWITCH}),
        .q(sync_q)
    );

    assign {scl_s, sda_s, tog_s, addr_low_s, addr_sup_s, sys_pg_s,
            a_ok_s, a_aux_s, a_firq_s, b_ok_s, b_aux_s, b_firq_s,
            a_inuv_s, a_outuv_s, a_ovl_s, therm_s, a_mf_s,
            sw_a_s, sw_b_s} = sync_q;

    // Floating or mid-supply select reads as one; only tied low gives zero
    assign addr_bit = ~addr_low_s;
    assign start_det = scl_s & cur_r.scl_prev & cur_r.sda_prev & ~sda_s;
    assign stop_det = scl_s & cur_r.scl_prev & ~cur_r.sda_prev & sda_s;
    assign scl_fall = cur_r.scl_prev & ~scl_s;
    assign bit_evt = tog_s ^ cur_r.tog_prev;
    assign word = {cur_r.shift[6:0], cap_bit};

    // Request status stays set whatever the allow bits say
    assign irq_a = a_firq_s | cur_r.sw_pend_a;
    assign irq_b = b_firq_s | cur_r.sw_pend_b;

    function automatic logic addr_match(input logic [7:0] w,
                                        input logic sel);
        addr_match = (w[7:1] == {TARGET_ADDR_HIGH, sel});
    endfunction : addr_match

    function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                            input port_state_type s,
                                            input logic [7:0] pstat,
                                            input logic [7:0] astat);
        unique case (idx)
            REG_POWER_STATUS: read_mux = pstat;
            REG_CONTROL_READBACK: read_mux = s.ctrl;
            REG_SLOT_A_FAULT_STATUS: read_mux = astat;
            default: read_mux = UNMAPPED_READ;
        endcase
    endfunction : read_mux

    logic [7:0] power_status;
    logic [7:0] slot_a_status;

    assign power_status = {1'b0, sys_pg_s, irq_b, b_aux_s, b_ok_s,
                           irq_a, a_aux_s, a_ok_s};
    assign slot_a_status = {a_mf_s, a_ok_s, cur_r.sw_a_filt, therm_s,
                            a_ovl_s, a_outuv_s, a_inuv_s,
                            cur_r.ctrl[CTRL_A_ENABLE]};

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.tog_prev = tog_s;
        cur_nxt.scl_prev = scl_s;
        cur_nxt.sda_prev = sda_s;
        cur_nxt.sda_out = 1'b0;
        if (stop_det)
        begin
            cur_nxt.state = LS_IDLE;
            cur_nxt.sda_oe = 1'b0;
        end
        else if (start_det)
        begin
            cur_nxt.state = LS_ADDR;
            cur_nxt.cnt = 3'h0;
            cur_nxt.sda_oe = 1'b0;
        end
        else
        begin
            if (bit_evt)
            begin
                cur_nxt.shift = word;
                cur_nxt.cnt = cur_r.cnt + 3'h1;
                unique case (cur_r.state)
                    LS_ADDR:
                        if (cur_r.cnt == BIT_LAST)
                        begin
                            cur_nxt.rw = cap_bit;
                            if (addr_match(word, addr_bit))
                                cur_nxt.state = LS_ADDR_ACK;
                            else
                                cur_nxt.state = LS_IGNORE;
                        end
                    LS_ADDR_ACK:
                    begin
                        cur_nxt.cnt = 3'h0;
                        if (cur_r.rw)
                        begin
                            cur_nxt.state = LS_READ_BITS;
                            cur_nxt.tx = read_mux(cur_r.index, cur_r,
                                                  power_status,
                                                  slot_a_status);
                        end
                        else
                            cur_nxt.state = LS_INDEX;
                    end
                    LS_INDEX:
                        if (cur_r.cnt == BIT_LAST)
                        begin
                            cur_nxt.index = word;
                            cur_nxt.state = LS_INDEX_ACK;
                        end
                    LS_INDEX_ACK:
                    begin
                        cur_nxt.cnt = 3'h0;
                        cur_nxt.state = LS_DATA;
                    end
                    LS_DATA:
                        if (cur_r.cnt == BIT_LAST)
                        begin
                            if (cur_r.index == REG_SLOT_CONTROL_WRITE)
                                cur_nxt.ctrl = word;
                            cur_nxt.state = LS_DATA_ACK;
                        end
                    LS_DATA_ACK:
                        cur_nxt.state = LS_IGNORE;
                    LS_READ_BITS:
                    begin
                        cur_nxt.tx = {cur_r.tx[6:0], 1'b0};
                        if (cur_r.cnt == BIT_LAST)
                            cur_nxt.state = LS_READ_ACK;
                    end
                    LS_READ_ACK:
                    begin
                        cur_nxt.cnt = 3'h0;
                        // Master acknowledge asks for the same register again
                        if (!cap_bit)
                        begin
                            cur_nxt.state = LS_READ_BITS;
                            cur_nxt.tx = read_mux(cur_r.index, cur_r,
                                                  power_status,
                                                  slot_a_status);
                        end
                        else
                            cur_nxt.state = LS_IGNORE;
                    end
                    LS_IDLE, LS_IGNORE: ;
                endcase
            end
            // Data line only changes while the serial clock is low
            if (scl_fall)
            begin
                unique case (cur_nxt.state)
                    LS_ADDR_ACK, LS_INDEX_ACK, LS_DATA_ACK:
                        cur_nxt.sda_oe = 1'b1;
                    LS_READ_BITS:
                        cur_nxt.sda_oe = ~cur_nxt.tx[7];
                    LS_IDLE, LS_ADDR, LS_INDEX, LS_DATA, LS_READ_ACK,
                    LS_IGNORE:
                        cur_nxt.sda_oe = 1'b0;
                endcase
            end
        end

        // Edge requests are held off while the reset bit stays at one
        cur_nxt.sw_a_prev = sw_a_s;
        cur_nxt.sw_b_prev = sw_b_s;
        if (cur_r.ctrl[CTRL_SW_RESET])
        begin
            cur_nxt.sw_pend_a = 1'b0;
            cur_nxt.sw_pend_b = 1'b0;
        end
        else
        begin
            if (sw_a_s != cur_r.sw_a_prev)
                cur_nxt.sw_pend_a = 1'b1;
            if (sw_b_s != cur_r.sw_b_prev)
                cur_nxt.sw_pend_b = 1'b1;
        end

        // Latch switch: counted delay on rise, immediate drop on fall
        if (!sw_a_s)
        begin
            cur_nxt.sw_a_filt = 1'b0;
            cur_nxt.dly_cnt = '0;
        end
        else if (cur_r.dly_cnt ==
                 DELAY_CNT_W'(SW_RISE_DELAY_CYCLES - 1))
            cur_nxt.sw_a_filt = 1'b1;
        else
            cur_nxt.dly_cnt = cur_r.dly_cnt + DELAY_CNT_W'(1);

        cur_nxt.irq_n = ~((irq_a & cur_r.ctrl[CTRL_A_ALLOW]) |
                          (irq_b & cur_r.ctrl[CTRL_B_ALLOW]));
        // Fault latches outside clear when these enables are cycled
        cur_nxt.en_a = cur_r.ctrl[CTRL_A_ENABLE];
        cur_nxt.en_b = cur_r.ctrl[CTRL_B_ENABLE];
        cur_nxt.test_mode = addr_sup_s;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cur_r <= '0;
            cur_r.state <= LINK_STATE_RESET;
            cur_r.ctrl <= CONTROL_RESET;
            cur_r.irq_n <= 1'b1;
            cur_r.scl_prev <= 1'b1;
            cur_r.sda_prev <= 1'b1;
        end
        else
            cur_r <= cur_nxt;
    end

    assign SDA_OUT = cur_r.sda_out;
    assign SDA_OE = cur_r.sda_oe;
    assign SLOT_A_ENABLE = cur_r.en_a;
    assign SLOT_B_ENABLE = cur_r.en_b;
    assign IRQ_N = cur_r.irq_n;
    assign TEST_MODE_MASK = cur_r.test_mode;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence addr_byte_done;
        cur_r.state == LS_ADDR && bit_evt && cur_r.cnt == BIT_LAST &&
        !stop_det && !start_det;
    endsequence

    sequence ack_slot_fall;
        (cur_r.state == LS_ADDR_ACK || cur_r.state == LS_INDEX_ACK ||
         cur_r.state == LS_DATA_ACK) && scl_fall && !bit_evt &&
        !stop_det && !start_det;
    endsequence

    a_foreign_addr: assert property (
        addr_byte_done and !addr_match(word, addr_bit) |=>
            cur_r.state == LS_IGNORE ##0 !SDA_OE)
        else $error("foreign address not ignored");

    a_own_addr: assert property (
        addr_byte_done and addr_match(word, addr_bit) |=>
            cur_r.state == LS_ADDR_ACK)
        else $error("own address not accepted");

    a_ack_drive: assert property (
        ack_slot_fall |=> SDA_OE && !SDA_OUT)
        else $error("acknowledge not driven low");

    a_stop_release: assert property (
        stop_det |=> !SDA_OE && cur_r.state == LS_IDLE)
        else $error("data line held after stop");

    a_ctrl_store: assert property (
        cur_r.state == LS_DATA && bit_evt && cur_r.cnt == BIT_LAST &&
        cur_r.index == REG_SLOT_CONTROL_WRITE && !stop_det && !start_det
        |=> cur_r.ctrl == $past(word))
        else $error("control write not stored");

    a_irq_gate: assert property (
        ((irq_a && cur_r.ctrl[CTRL_A_ALLOW]) ||
         (irq_b && cur_r.ctrl[CTRL_B_ALLOW])) |=> !IRQ_N)
        else $error("allowed interrupt not on pin");

    a_irq_masked: assert property (
        !cur_r.ctrl[CTRL_A_ALLOW] && !cur_r.ctrl[CTRL_B_ALLOW] |=> IRQ_N)
        else $error("masked interrupt reached pin");

    a_sw_rise_wait: assert property (
        $rose(sw_a_s) |-> !cur_r.sw_a_filt [*8])
        else $error("latch switch rise not delayed");

    a_sw_fall_fast: assert property (
        !sw_a_s |=> !cur_r.sw_a_filt)
        else $error("latch switch fall delayed");

    a_sw_reset_hold: assert property (
        cur_r.ctrl[CTRL_SW_RESET] [*2] |-> !cur_r.sw_pend_a &&
            !cur_r.sw_pend_b)
        else $error("switch request not reset");

    a_enable_follow: assert property (
        ##1 SLOT_A_ENABLE == $past(cur_r.ctrl[CTRL_A_ENABLE]) &&
            SLOT_B_ENABLE == $past(cur_r.ctrl[CTRL_B_ENABLE]))
        else $error("slot enable not following control");

    a_status_top: assert property (
        $rose(cur_r.state == LS_READ_BITS) &&
        cur_r.index == REG_POWER_STATUS |-> !cur_r.tx[7] &&
            cur_r.tx[6] == $past(sys_pg_s))
        else $error("status top bits wrong");
endmodule : hp_register_port
`default_nettype wire

// ---- tb/two_wire_master.sv ----
// Behavioural two-wire bus master for the register port bench
`default_nettype none
module two_wire_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Clock pulses with data released, so link flops see reset
    task automatic idle_pulses();
        repeat (2)
        begin
            #30 scl = 1'b0;
            #30 scl = 1'b1;
        end
    endtask : idle_pulses
    // Also serves as repeated start
    task automatic start_cond();
        #60 sda_low = 1'b0;
        #60 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #60 sda_low = 1'b1;
        #60 scl = 1'b1;
        #40 sda_low = 1'b0;
        #100;
    endtask : stop_cond
    // Low phase leaves room for the target's lagging drive to settle
    task automatic bit_io(input logic b, output logic v);
        #60 sda_low = ~b;
        #60 scl = 1'b1;
        #79 v = sda;
        #1 scl = 1'b0;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, input logic ack_in,
        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask : byte_io
endmodule : two_wire_master
`default_nettype wire

// ---- tb/tb_hp_register_port.sv ----
// Self-checking bench for the hot-plug two-wire register port
`default_nettype none
module tb_hp_register_port;
    import hp_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RST_B, scl, m_low, sda, d_out, d_oe, pin_low, pin_sup;
    logic sys_pg, a_ok, a_aux, a_irq, b_ok, b_aux, b_irq, in_uv, out_uv;
    logic ovl, therm, a_main, sw_a, sw_b, en_a, en_b, irq_n, tmask;
    logic [6:0] dev;
    logic [7:0] q;
    int n_errors = 0;
    int check_count = 0;
    // Open-drain data wire with pull-up
    assign sda = ~(m_low | d_oe);
    two_wire_master m (.scl(scl), .sda_low(m_low), .sda(sda));
    hp_register_port i_hp_register_port (
        .CLK(CLK), .RST_B(RST_B), .SCL_CLK(scl), .SDA_IN(sda),
        .SDA_OUT(d_out), .SDA_OE(d_oe), .ADDRESS_SELECT_PIN_LOW(pin_low),
        .ADDRESS_SELECT_PIN_SUPPLY(pin_sup), .SYSTEM_POWER_GOOD(sys_pg),
        .SLOT_A_POWER_HEALTHY(a_ok), .SLOT_A_AUX_HEALTHY(a_aux),
        .SLOT_A_FAULT_IRQ(a_irq), .SLOT_B_POWER_HEALTHY(b_ok),
        .SLOT_B_AUX_HEALTHY(b_aux), .SLOT_B_FAULT_IRQ(b_irq),
        .SLOT_A_IN_UV_FAULT(in_uv), .SLOT_A_OUT_UV_FAULT(out_uv),
        .SLOT_A_OVERLOAD(ovl), .THERMAL_FAULT(therm),
        .SLOT_A_MAIN_FAULT(a_main), .SLOT_A_LATCH_SWITCH(sw_a),
        .SLOT_B_LATCH_SWITCH(sw_b), .SLOT_A_ENABLE(en_a),
        .SLOT_B_ENABLE(en_b), .IRQ_N(irq_n), .TEST_MODE_MASK(tmask));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask : wait_clk
    task automatic reg_write(input logic [6:0] a, input logic [7:0] idx,
        input logic [7:0] d, input logic ok);
        logic [7:0] w [3];
        logic [7:0] r;
        logic k;
        w = '{{a, 1'b0}, idx, d};
        m.start_cond();
        for (int i = 0; i < 3; i++)
        begin
            m.byte_io(w[i], 1'b1, r, k);
            check({7'h0, k}, {7'h0, ~ok});
        end
        m.stop_cond();
    endtask : reg_write
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
        logic [7:0] r;
        logic k;
        m.start_cond();
        m.byte_io({dev, 1'b0}, 1'b1, r, k);
        m.byte_io(idx, 1'b1, r, k);
        check({7'h0, k}, 8'h00);
        m.start_cond();
        m.byte_io({dev, 1'b1}, 1'b1, r, k);
        check({7'h0, k}, 8'h00);
        m.byte_io(8'hFF, 1'b1, d, k);
        check({7'h0, k}, 8'h01);
        m.stop_cond();
    endtask : reg_read
    task automatic t_reset();
        check({5'h0, d_oe, en_a, en_b}, 8'h00);
        check({7'h0, irq_n}, 8'h01);
        reg_read(REG_CONTROL_READBACK, q);
        check(q, CONTROL_RESET);
    endtask : t_reset
    task automatic t_ctrl();
        logic [7:0] v [2];
        v = '{8'hEA, 8'h35};
        foreach (v[i])
        begin
            reg_write(dev, REG_SLOT_CONTROL_WRITE, v[i], 1'b1);
            check({6'h0, en_a, en_b}, {6'h0, v[i][1], v[i][3]});
            reg_read(REG_CONTROL_READBACK, q);
            check(q, v[i]);
        end
        reg_write(dev, REG_CONTROL_READBACK, 8'h00, 1'b1);
        reg_read(REG_CONTROL_READBACK, q);
        check(q, 8'h35);
    endtask : t_ctrl
    task automatic t_addr();
        reg_write({TARGET_ADDR_HIGH, 1'b0}, 8'h00, 8'hFF, 1'b0);
        reg_read(REG_CONTROL_READBACK, q);
        check(q, 8'h35);
        pin_low = 1'b1;
        dev = {TARGET_ADDR_HIGH, 1'b0};
        wait_clk(10);
        reg_read(REG_CONTROL_READBACK, q);
        check(q, 8'h35);
        pin_low = 1'b0;
        pin_sup = 1'b1;
        dev = {TARGET_ADDR_HIGH, 1'b1};
        wait_clk(10);
        check({7'h0, tmask}, 8'h01);
        pin_sup = 1'b0;
        wait_clk(10);
        check({7'h0, tmask}, 8'h00);
    endtask : t_addr
    task automatic t_status();
        {sys_pg, b_irq, b_aux, b_ok, a_irq, a_aux, a_ok} = 7'h55;
        reg_read(REG_POWER_STATUS, q);
        check(q, 8'h55);
        sys_pg = 1'b0;
        reg_read(REG_POWER_STATUS, q);
        check(q, 8'h15);
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h02, 1'b1);
        {in_uv, out_uv, ovl, therm, a_main} = 5'h1F;
        reg_read(REG_SLOT_A_FAULT_STATUS, q);
        check(q, 8'hDF);
        check(q & 8'hC0, 8'hC0);
    endtask : t_status
    task automatic t_irq();
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h01, 1'b1);
        check({7'h0, irq_n}, 8'h00);
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h04, 1'b1);
        check({7'h0, irq_n}, 8'h01);
        reg_read(REG_POWER_STATUS, q);
        check(q, 8'h15);
        b_irq = 1'b1;
        wait_clk(10);
        check({7'h0, irq_n}, 8'h00);
        b_irq = 1'b0;
        a_irq = 1'b0;
    endtask : t_irq
    task automatic t_switch();
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h00, 1'b1);
        sw_a = 1'b1;
        reg_read(REG_SLOT_A_FAULT_STATUS, q);
        check({7'h0, q[5]}, 8'h00);
        reg_read(REG_POWER_STATUS, q);
        check({7'h0, q[2]}, 8'h01);
        wait_clk(400);
        reg_read(REG_SLOT_A_FAULT_STATUS, q);
        check({7'h0, q[5]}, 8'h01);
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h10, 1'b1);
        reg_read(REG_POWER_STATUS, q);
        check({7'h0, q[2]}, 8'h00);
        reg_write(dev, REG_SLOT_CONTROL_WRITE, 8'h00, 1'b1);
        sw_a = 1'b0;
        sw_b = 1'b1;
        wait_clk(10);
        reg_read(REG_SLOT_A_FAULT_STATUS, q);
        check({7'h0, q[5]}, 8'h00);
        reg_read(REG_POWER_STATUS, q);
        check({6'h0, q[5], q[2]}, 8'h03);
    endtask : t_switch
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial
    begin
        #1_000_000;
        n_errors++;
        final_report();
    end
    initial
    begin
        RST_B = 1'b0;
        {pin_low, pin_sup, sys_pg, a_ok, a_aux, a_irq, b_ok} = 7'h00;
        {b_aux, b_irq, in_uv, out_uv, ovl, therm, a_main, sw_a} = 8'h00;
        sw_b = 1'b0;
        dev = {TARGET_ADDR_HIGH, 1'b1};
        m.idle_pulses();
        wait_clk(3);
        RST_B = 1'b1;
        wait_clk(4);
        t_reset();
        t_ctrl();
        t_addr();
        t_status();
        t_irq();
        t_switch();
        final_report();
    end
endmodule : tb_hp_register_port
`default_nettype wire
